// ==== sgmb_mgmt_regs.sv ====
// SGMII management register bank with its MDIO slave.
// Assumes MDC and MDIO input are synchronous to the core clock and
// that MDC is several core clocks per phase.
`timescale 1ns/1ps

// Summary of operation
// (RQ1) Extended status bit 15 reads one always
// (RQ2) Extended status bits 14..0 read zero
// (RQ3) Enabled interrupt sets status on autoneg completion
// (RQ4) Status stays set until station writes zero
// (RQ5) Disabled interrupt forces status to zero
// (RQ6) Interrupt output mirrors the status bit
// (RQ7) Interrupt enable is read/write, defaults one
// (RQ8) Undefined addresses read zero, ignore writes
// (RQ9) Hard, lock-loss or soft reset restores defaults
// (RQ10) Loopback bit drives internal or external loopback
// (RQ11) Speed bits read zero and one
// (RQ12) Autoneg enable read/write, defaults one
// (RQ13) Power down sticky, cleared by core reset
// (RQ14) Isolate defaults one and isolates GMII
// (RQ15) Restart autoneg bit self clears
// (RQ16) Duplex reads one, collision test zero
// (RQ17) Unidirectional enable allows transmit, defaults zero
// (RQ18) Control bits 4..0 read zero, writes ignored
// (RQ19) Writes to constant bits change nothing
module sgmb_mgmt_regs
	import sgmb_pkg::*;
#(
	parameter bit P_TBI_MODE = 1'b0
) (
	// Clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_clock_manager_locked,
	// MDIO pins
	input wire logic i_mdc,
	input wire logic i_mdio_i,
	output logic o_mdio_o,
	output logic o_mdio_oe,
	input wire logic [4:0] i_phy_addr,
	// Words for registers 1 to 4, built elsewhere
	input wire logic [15:0] i_link_status_word,
	input wire logic [15:0] i_phy_id_high_word,
	input wire logic [15:0] i_phy_id_low_word,
	input wire logic [15:0] i_an_adv_word,
	// Auto-negotiation events
	input wire logic i_an_complete,
	output logic o_autoneg_irq_output,
	// Core controls
	output logic o_soft_reset,
	output logic o_loopback_en,
	output logic o_ewrap,
	output logic o_an_enable,
	output logic o_power_down,
	output logic o_isolate,
	output logic o_an_restart,
	output logic o_unidir_en
);

	localparam sgmb_regs_s C_RST = '{
		st: SGMB_IDLE,
		hist: '0,
		cnt: '0,
		sh: '0,
		op: '0,
		reg_addr: '0,
		hit: 1'b0,
		mdc_q: 1'b0,
		mdio_o: 1'b0,
		mdio_oe: 1'b0,
		loopback: SGMB_RST_LOOPBACK,
		an_enable: SGMB_RST_AN_ENABLE,
		power_down: SGMB_RST_POWER_DOWN,
		isolate: SGMB_RST_ISOLATE,
		an_restart: SGMB_RST_AN_RESTART,
		unidir: SGMB_RST_UNIDIR,
		irq_status: SGMB_RST_IRQ_STATUS,
		irq_enable: SGMB_RST_IRQ_ENABLE,
		soft_reset: 1'b0
	};

	logic [1:0] rst_sync_r;
	logic rst_n;
	sgmb_regs_s r;
	sgmb_regs_s n;
	logic mdc_rise;
	logic [15:0] rd_word;
	logic [15:0] wr_word;
	logic [11:0] head;
	logic wr_commit;

	// Reset release through two flops
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	assign mdc_rise = i_mdc & ~r.mdc_q;
	assign head = {r.sh[10:0], i_mdio_i};
	assign wr_word = {r.sh[14:0], i_mdio_i};

	// Read data for the addressed register
	always_comb begin
		rd_word = '0; // RQ8
		case (r.reg_addr)
			SGMB_ADDR_CONTROL: begin
				rd_word[SGMB_CTL_RESET] = 1'b0;
				rd_word[SGMB_CTL_LOOPBACK] = r.loopback;
				rd_word[SGMB_CTL_SPEED_LSB] = SGMB_FIX_SPEED_LSB; // RQ11
				rd_word[SGMB_CTL_AN_ENABLE] = r.an_enable;
				rd_word[SGMB_CTL_POWER_DOWN] = r.power_down;
				rd_word[SGMB_CTL_ISOLATE] = r.isolate;
				rd_word[SGMB_CTL_AN_RESTART] = r.an_restart;
				rd_word[SGMB_CTL_DUPLEX] = SGMB_FIX_DUPLEX; // RQ16
				rd_word[SGMB_CTL_COL_TEST] = SGMB_FIX_COL_TEST; // RQ16
				rd_word[SGMB_CTL_SPEED_MSB] = SGMB_FIX_SPEED_MSB; // RQ11
				rd_word[SGMB_CTL_UNIDIR] = r.unidir;
				// Bits 4..0 stay zero
			end
			SGMB_ADDR_LINK_STATUS: rd_word = i_link_status_word;
			SGMB_ADDR_ID_HIGH: rd_word = i_phy_id_high_word;
			SGMB_ADDR_ID_LOW: rd_word = i_phy_id_low_word;
			SGMB_ADDR_AN_ADV: rd_word = i_an_adv_word;
			SGMB_ADDR_EXT_STATUS: begin
				rd_word = SGMB_EXT_STATUS_VALUE; // RQ1 RQ2
			end
			SGMB_ADDR_AN_IRQ: begin
				rd_word[SGMB_IRQ_STATUS] = r.irq_status;
				rd_word[SGMB_IRQ_ENABLE] = r.irq_enable;
			end
			default: rd_word = '0; // RQ8
		endcase
	end

	always_comb begin
		n = r;
		wr_commit = 1'b0;
		n.mdc_q = i_mdc;
		n.soft_reset = 1'b0;
		// Restart is a one-cycle request, then reads back zero
		n.an_restart = 1'b0; // RQ15

		// Management frame engine, one step per MDC rise
		if (mdc_rise) begin
			case (r.st)
				SGMB_IDLE: begin
					n.hist = {r.hist[1:0], i_mdio_i};
					n.mdio_oe = 1'b0;
					// Preamble one, then start bits 0 and 1
					if ({r.hist[1:0], i_mdio_i} == SGMB_START_SEEN) begin
						n.st = SGMB_HEAD;
						n.cnt = '0;
					end
				end
				SGMB_HEAD: begin
					n.sh = {r.sh[14:0], i_mdio_i};
					n.cnt = r.cnt + 5'h01;
					if (r.cnt == SGMB_HEAD_LAST) begin
						n.op = head[SGMB_OP_HI:SGMB_OP_LO];
						n.reg_addr = head[SGMB_REG_HI:SGMB_REG_LO];
						n.hit = (head[SGMB_PHY_HI:SGMB_PHY_LO] == i_phy_addr);
						n.cnt = '0;
						n.st = SGMB_TURN;
						if (head[SGMB_OP_HI:SGMB_OP_LO] != SGMB_OP_READ &&
							head[SGMB_OP_HI:SGMB_OP_LO] != SGMB_OP_WRITE) begin
							n.st = SGMB_IDLE;
							n.hist = '0;
						end
					end
				end
				SGMB_TURN: begin
					n.cnt = r.cnt + 5'h01;
					if (r.cnt == SGMB_TURN_LAST) begin
						n.st = SGMB_DATA;
						n.cnt = '0;
						n.sh = rd_word;
						n.mdio_o = rd_word[SGMB_WORD_MSB];
					end else if (r.hit && r.op == SGMB_OP_READ) begin
						// Second turnaround bit is driven low
						n.mdio_oe = 1'b1;
						n.mdio_o = 1'b0;
					end
				end
				SGMB_DATA: begin
					n.cnt = r.cnt + 5'h01;
					if (r.op == SGMB_OP_READ) begin
						n.sh = {r.sh[14:0], 1'b0};
						n.mdio_o = r.sh[SGMB_WORD_MSB - 1];
					end else begin
						n.sh = wr_word;
					end
					if (r.cnt == SGMB_DATA_LAST) begin
						n.st = SGMB_IDLE;
						n.hist = '0;
						n.mdio_oe = 1'b0;
						n.mdio_o = 1'b0;
						wr_commit = r.hit && (r.op == SGMB_OP_WRITE);
					end
				end
				default: begin
					n.st = SGMB_IDLE;
					n.hist = '0;
					n.mdio_oe = 1'b0;
				end
			endcase
		end

		// Register writes; constant and reserved bits are not stored
		if (wr_commit) begin
			case (r.reg_addr)
				SGMB_ADDR_CONTROL: begin // RQ18 RQ19
					n.loopback = wr_word[SGMB_CTL_LOOPBACK]; // RQ10
					n.an_enable = wr_word[SGMB_CTL_AN_ENABLE]; // RQ12
					// Only a core reset can bring this back to zero
					n.power_down = r.power_down |
						wr_word[SGMB_CTL_POWER_DOWN]; // RQ13
					n.isolate = wr_word[SGMB_CTL_ISOLATE]; // RQ14
					n.an_restart = wr_word[SGMB_CTL_AN_RESTART]; // RQ15
					n.unidir = wr_word[SGMB_CTL_UNIDIR]; // RQ17
					n.soft_reset = wr_word[SGMB_CTL_RESET]; // RQ9
				end
				SGMB_ADDR_AN_IRQ: begin
					n.irq_enable = wr_word[SGMB_IRQ_ENABLE]; // RQ7
					// Writing one leaves the flag alone
					if (!wr_word[SGMB_IRQ_STATUS]) begin
						n.irq_status = 1'b0; // RQ4
					end
				end
				default: ; // RQ8
			endcase
		end

		// A completion in the clearing cycle still sets the flag
		if (i_an_complete && r.irq_enable) begin
			n.irq_status = 1'b1; // RQ3 RQ4
		end
		if (!n.irq_enable) begin
			n.irq_status = 1'b0; // RQ5
		end

		// Lock loss or soft reset: registers back to defaults
		if (!i_clock_manager_locked || n.soft_reset) begin // RQ9
			n.loopback = C_RST.loopback;
			n.an_enable = C_RST.an_enable;
			n.power_down = C_RST.power_down; // RQ13
			n.isolate = C_RST.isolate;
			n.an_restart = C_RST.an_restart;
			n.unidir = C_RST.unidir;
			n.irq_status = C_RST.irq_status;
			n.irq_enable = C_RST.irq_enable;
		end
	end

	// Clock enable low freezes everything but the reset path, frame engine included
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r <= C_RST; // RQ9
		end else if (!rst_n) begin
			r <= C_RST;
		end else if (i_ce) begin
			r <= n;
		end
	end

	assign o_mdio_o = r.mdio_o;
	assign o_mdio_oe = r.mdio_oe;
	assign o_autoneg_irq_output = r.irq_status; // RQ6
	assign o_soft_reset = r.soft_reset;
	// Transceiver loopback versus request to the external PMA
	assign o_loopback_en = r.loopback & ~P_TBI_MODE; // RQ10
	assign o_ewrap = r.loopback & P_TBI_MODE; // RQ10
	assign o_an_enable = r.an_enable; // RQ12
	// No effect in the ten-bit interface variant
	assign o_power_down = r.power_down & ~P_TBI_MODE; // RQ13
	assign o_isolate = r.isolate; // RQ14
	assign o_an_restart = r.an_restart; // RQ15
	assign o_unidir_en = r.unidir; // RQ17

endmodule

// ==== sgmb_mgmt_regs_assertions.sv ====
// Pin checker for the SGMII management register bank.
// Assumes it is bound onto sgmb_mgmt_regs; one clock domain.
`timescale 1ns/1ps
module sgmb_mgmt_regs_assertions #(
	parameter bit P_TBI_MODE = 1'b0
) (
	// Inputs
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_clock_manager_locked,
	input wire logic i_mdc,
	input wire logic i_an_complete,
	// Outputs
	input wire logic o_autoneg_irq_output,
	input wire logic o_soft_reset,
	input wire logic o_loopback_en,
	input wire logic o_ewrap,
	input wire logic o_an_enable,
	input wire logic o_power_down,
	input wire logic o_isolate,
	input wire logic o_an_restart,
	input wire logic o_unidir_en
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_dflt;
		o_isolate && o_an_enable && !o_loopback_en && !o_power_down
			&& !o_unidir_en;
	endsequence
	property p_irq_set;
		$rose(o_autoneg_irq_output) |-> $past(i_an_complete);
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("irq set alone");
	// Three quiet MDC samples leave no write in flight
	property p_irq_hold;
		(!i_mdc && i_clock_manager_locked)[*3] ##0 o_autoneg_irq_output
			|=> o_autoneg_irq_output;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("irq dropped");
	property p_lock;
		!i_clock_manager_locked && i_ce |=> s_dflt;
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock loss kept state");
	property p_soft;
		o_soft_reset |-> s_dflt;
	endproperty
	a_soft: assert property (p_soft)
		else $error("soft reset kept state");
	property p_rst;
		$rose(i_arst_n) |-> s_dflt;
	endproperty
	a_rst: assert property (p_rst)
		else $error("bad reset state");
	property p_restart;
		o_an_restart |=> !o_an_restart;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart stuck");
	property p_pd;
		$fell(o_power_down) |-> o_soft_reset
			|| !$past(i_clock_manager_locked);
	endproperty
	a_pd: assert property (p_pd)
		else $error("power down cleared");
	property p_lb;
		o_loopback_en || o_ewrap |-> o_ewrap == P_TBI_MODE;
	endproperty
	a_lb: assert property (p_lb)
		else $error("wrong loopback pin");
	c_irq: cover property ($rose(o_autoneg_irq_output));
	c_soft: cover property (o_soft_reset);
	c_pd: cover property ($fell(o_power_down));
endmodule

// ==== sgmb_pkg.sv ====
// Constants and types for the SGMII management register bank.
// Assumes a single core clock domain; the MDIO pins are sampled on it.
package sgmb_pkg;

	// Register addresses on the management frame
	localparam logic [4:0] SGMB_ADDR_CONTROL = 5'h00;
	localparam logic [4:0] SGMB_ADDR_LINK_STATUS = 5'h01;
	localparam logic [4:0] SGMB_ADDR_ID_HIGH = 5'h02;
	localparam logic [4:0] SGMB_ADDR_ID_LOW = 5'h03;
	localparam logic [4:0] SGMB_ADDR_AN_ADV = 5'h04;
	localparam logic [4:0] SGMB_ADDR_EXT_STATUS = 5'h0F;
	localparam logic [4:0] SGMB_ADDR_AN_IRQ = 5'h10;

	// Control register field positions
	localparam int SGMB_CTL_RESET = 15;
	localparam int SGMB_CTL_LOOPBACK = 14;
	localparam int SGMB_CTL_SPEED_LSB = 13;
	localparam int SGMB_CTL_AN_ENABLE = 12;
	localparam int SGMB_CTL_POWER_DOWN = 11;
	localparam int SGMB_CTL_ISOLATE = 10;
	localparam int SGMB_CTL_AN_RESTART = 9;
	localparam int SGMB_CTL_DUPLEX = 8;
	localparam int SGMB_CTL_COL_TEST = 7;
	localparam int SGMB_CTL_SPEED_MSB = 6;
	localparam int SGMB_CTL_UNIDIR = 5;

	// Control register defaults and constant bits
	localparam logic SGMB_RST_LOOPBACK = 1'h0;
	localparam logic SGMB_RST_AN_ENABLE = 1'h1;
	localparam logic SGMB_RST_POWER_DOWN = 1'h0;
	localparam logic SGMB_RST_ISOLATE = 1'h1;
	localparam logic SGMB_RST_AN_RESTART = 1'h0;
	localparam logic SGMB_RST_UNIDIR = 1'h0;
	localparam logic SGMB_FIX_SPEED_LSB = 1'h0;
	localparam logic SGMB_FIX_DUPLEX = 1'h1;
	localparam logic SGMB_FIX_COL_TEST = 1'h0;
	localparam logic SGMB_FIX_SPEED_MSB = 1'h1;

	// Extended status: only 1000BASE-X full duplex advertised
	localparam logic [15:0] SGMB_EXT_STATUS_VALUE = 16'h8000;

	// Interrupt control register fields and defaults
	localparam int SGMB_IRQ_STATUS = 1;
	localparam int SGMB_IRQ_ENABLE = 0;
	localparam logic SGMB_RST_IRQ_STATUS = 1'h0;
	localparam logic SGMB_RST_IRQ_ENABLE = 1'h1;

	// Management frame layout
	localparam logic [2:0] SGMB_START_SEEN = 3'h5;
	localparam logic [1:0] SGMB_OP_READ = 2'h2;
	localparam logic [1:0] SGMB_OP_WRITE = 2'h1;
	localparam logic [4:0] SGMB_HEAD_LAST = 5'h0B;
	localparam logic [4:0] SGMB_TURN_LAST = 5'h01;
	localparam logic [4:0] SGMB_DATA_LAST = 5'h0F;
	localparam int SGMB_OP_HI = 11;
	localparam int SGMB_OP_LO = 10;
	localparam int SGMB_PHY_HI = 9;
	localparam int SGMB_PHY_LO = 5;
	localparam int SGMB_REG_HI = 4;
	localparam int SGMB_REG_LO = 0;
	localparam int SGMB_WORD_MSB = 15;

	typedef enum logic [1:0] {
		SGMB_IDLE,
		SGMB_HEAD,
		SGMB_TURN,
		SGMB_DATA
	} sgmb_state_e;

	typedef struct packed {
		sgmb_state_e st;
		logic [2:0] hist;
		logic [4:0] cnt;
		logic [15:0] sh;
		logic [1:0] op;
		logic [4:0] reg_addr;
		logic hit;
		logic mdc_q;
		logic mdio_o;
		logic mdio_oe;
		logic loopback;
		logic an_enable;
		logic power_down;
		logic isolate;
		logic an_restart;
		logic unidir;
		logic irq_status;
		logic irq_enable;
		logic soft_reset;
	} sgmb_regs_s;

endpackage

// ==== sgmb_station.sv ====
// MDIO station model: drives MDC and MDIO, reads the line back.
// Assumes MDC phases of two core clocks; MDC rests low.
`timescale 1ns/1ps
module sgmb_station (
	// Clock and resolved line
	input wire logic i_clk,
	input wire logic i_line,
	// Drive; one stands for the pull-up
	output logic o_mdc,
	output logic o_mdio
);
	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
	end
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [33:0] b;
		// Read releases turnaround and data
		b = {4'hD, op, phy, ra, op[1] ? 18'h3FFFF : {2'h2, wd}};
		rd = 16'h0000;
		for (int i = 33; i >= 0; i--) begin
			@(posedge i_clk);
			o_mdc <= 1'b0;
			o_mdio <= b[i];
			repeat (2) @(posedge i_clk);
			if (i < 16)
				rd[i] = i_line;
			o_mdc <= 1'b1;
			@(posedge i_clk);
		end
		@(posedge i_clk);
		o_mdc <= 1'b0;
		o_mdio <= 1'b1;
		repeat (6) @(posedge i_clk);
	endtask
endmodule

// ==== tb_sgmii_mgmt_register_bank.sv ====
// Bench: station model drives the bank over MDIO.
// Assumes package, station and checker compiled first.
`timescale 1ns/1ps
module tb_sgmii_mgmt_register_bank
	import sgmb_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic lock = 1'b1;
	logic anc = 1'b0;
	logic [4:0] phy = 5'h03;
	logic mdc, mdo, mo, moe, irq, lb, ew, ane, pd, iso, anr, uni;
	// Second bank in the ten-bit interface variant, other address
	logic mo2, moe2, lb2, ew2, pd2, srst;
	logic ce = 1'b1;
	logic [15:0] rd;
	wire line = moe ? mo : (moe2 ? mo2 : mdo);
	int miscompares = 0;
	int cmp_count = 0;
	int nres = 0;
	int nsr = 0;
	always #20 clk = ~clk;
	always @(posedge clk)
		if (anr === 1'b1)
			nres++;
	always @(posedge clk)
		if (srst === 1'b1)
			nsr++;
	sgmb_station u_sgmb_station (.i_clk(clk), .i_line(line),
		.o_mdc(mdc), .o_mdio(mdo));
	sgmb_mgmt_regs u_sgmb_mgmt_regs (.i_core_clk(clk), .i_arst_n(rst_n),
		.i_ce(ce), .i_clock_manager_locked(lock), .i_mdc(mdc),
		.i_mdio_i(line), .o_mdio_o(mo), .o_mdio_oe(moe), .i_phy_addr(phy),
		.i_link_status_word(16'h01A5), .i_phy_id_high_word(16'h0000),
		.i_phy_id_low_word(16'h0000), .i_an_adv_word(16'h0001),
		.i_an_complete(anc), .o_autoneg_irq_output(irq),
		.o_soft_reset(srst), .o_loopback_en(lb), .o_ewrap(ew),
		.o_an_enable(ane), .o_power_down(pd), .o_isolate(iso),
		.o_an_restart(anr), .o_unidir_en(uni));
	sgmb_mgmt_regs #(.P_TBI_MODE(1'b1)) u_sgmb_mgmt_regs_tbi (
		.i_core_clk(clk), .i_arst_n(rst_n), .i_ce(ce),
		.i_clock_manager_locked(lock), .i_mdc(mdc), .i_mdio_i(line),
		.o_mdio_o(mo2), .o_mdio_oe(moe2), .i_phy_addr(5'h04),
		.i_link_status_word(16'h0000), .i_phy_id_high_word(16'h0000),
		.i_phy_id_low_word(16'h0000), .i_an_adv_word(16'h0000),
		.i_an_complete(anc), .o_autoneg_irq_output(), .o_soft_reset(),
		.o_loopback_en(lb2), .o_ewrap(ew2), .o_an_enable(),
		.o_power_down(pd2), .o_isolate(), .o_an_restart(),
		.o_unidir_en());
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		u_sgmb_station.xfer(SGMB_OP_WRITE, phy, ra, d, rd);
	endtask
	task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
		u_sgmb_station.xfer(SGMB_OP_READ, phy, ra, 16'h0000, rd);
		chk(rd, e);
	endtask
	task automatic pulse();
		@(posedge clk);
		anc <= 1'b1;
		@(posedge clk);
		anc <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic finish_test();
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_const();
		wr(SGMB_ADDR_EXT_STATUS, 16'h0000);
		wr(5'h07, 16'hFFFF);
		rdc(SGMB_ADDR_CONTROL, 16'h1540);
		rdc(SGMB_ADDR_EXT_STATUS, 16'h8000);
		rdc(SGMB_ADDR_AN_IRQ, 16'h0001);
		rdc(5'h07, 16'h0000);
		rdc(SGMB_ADDR_LINK_STATUS, 16'h01A5);
		rdc(SGMB_ADDR_AN_ADV, 16'h0001);
		chk(16'({ane, iso, uni}), 16'h0006);
	endtask
	task automatic t_ctl();
		wr(SGMB_ADDR_CONTROL, 16'h7FFF);
		rdc(SGMB_ADDR_CONTROL, 16'h5D60);
		chk(16'({lb, ew, pd, uni}), 16'h000B);
		chk(16'(nres), 16'h0001);
		wr(SGMB_ADDR_CONTROL, 16'h0000);
		rdc(SGMB_ADDR_CONTROL, 16'h0940);
		wr(SGMB_ADDR_CONTROL, 16'h8000);
		rdc(SGMB_ADDR_CONTROL, 16'h1540);
		chk(16'(nsr), 16'h0001);
	endtask
	task automatic t_irq();
		pulse();
		chk(16'(irq), 16'h0001);
		wr(SGMB_ADDR_AN_IRQ, 16'h0003);
		rdc(SGMB_ADDR_AN_IRQ, 16'h0003);
		wr(SGMB_ADDR_AN_IRQ, 16'h0001);
		rdc(SGMB_ADDR_AN_IRQ, 16'h0001);
		pulse();
		wr(SGMB_ADDR_AN_IRQ, 16'h0002);
		rdc(SGMB_ADDR_AN_IRQ, 16'h0000);
		pulse();
		chk(16'(irq), 16'h0000);
	endtask
	task automatic t_rst();
		wr(SGMB_ADDR_CONTROL, 16'h4820);
		lock <= 1'b0;
		repeat (3) @(posedge clk);
		lock <= 1'b1;
		rdc(SGMB_ADDR_CONTROL, 16'h1540);
		wr(SGMB_ADDR_AN_IRQ, 16'h0000);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(SGMB_ADDR_AN_IRQ, 16'h0001);
	endtask
	// Enable low: a completion pulse must be lost
	task automatic t_ce();
		ce <= 1'b0;
		pulse();
		ce <= 1'b1;
		@(posedge clk);
		chk(16'(irq), 16'h0000);
		pulse();
		chk(16'(irq), 16'h0001);
	endtask
	// Variant pins, foreign address and refused opcodes
	task automatic t_tbi();
		u_sgmb_station.xfer(SGMB_OP_WRITE, 5'h04, SGMB_ADDR_CONTROL,
			16'h4800, rd);
		chk(16'({lb2, ew2, pd2, lb, pd}), 16'h0008);
		u_sgmb_station.xfer(SGMB_OP_READ, 5'h04, SGMB_ADDR_CONTROL,
			16'h0000, rd);
		chk(rd, 16'h4940);
		rdc(SGMB_ADDR_CONTROL, 16'h1540);
		u_sgmb_station.xfer(SGMB_OP_READ, 5'h1F, SGMB_ADDR_CONTROL,
			16'h0000, rd);
		chk(rd, 16'hFFFF);
		u_sgmb_station.xfer(2'h0, phy, SGMB_ADDR_CONTROL, 16'h0000, rd);
		u_sgmb_station.xfer(2'h3, phy, SGMB_ADDR_CONTROL, 16'h0000, rd);
		chk(rd, 16'hFFFF);
		rdc(SGMB_ADDR_CONTROL, 16'h1540);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_const();
		t_ctl();
		t_irq();
		t_rst();
		t_ce();
		t_tbi();
		finish_test();
	end
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		finish_test();
	end
endmodule
bind sgmb_mgmt_regs sgmb_mgmt_regs_assertions #(
	.P_TBI_MODE(P_TBI_MODE)
) u_sgmb_mgmt_regs_assertions (
	.i_core_clk, .i_arst_n, .i_ce, .i_clock_manager_locked, .i_mdc,
	.i_an_complete, .o_autoneg_irq_output, .o_soft_reset, .o_loopback_en,
	.o_ewrap, .o_an_enable, .o_power_down, .o_isolate, .o_an_restart,
	.o_unidir_en
);
